// file: hw/cpu_pipeline_stage_flow.sv
// cpu_pipeline_stage_flow: scalar in-order pipeline fetch, expand, operand fetch, execute, cache, cache2, writeback
// assumes: instruction and data caches with translation answer in the same cycle on core_clk, APB master on core_clk
// Functional notes
// - fetch indexes low 11 bits, checks tag, adds 4
// - compressed mode expands short words before operand fetch
// - two register reads with execute and cache bypass
// - execute drives ALU, latches result
// - add passes result through cache stage
// - writeback writes destination register
// - jump-link loads pc, link is pc+8 or +4
// - link travels execute, cache, writeback latches
// - empty jump-link destination means register 31
// - branch-equal compares operands, picks next pc
// - branch pc valid at next fetch; later stages idle
// - trap-less-than subtracts, traps, kills younger work
// - trap writeback records return address, code, flags
// - no trap-less-than in compressed mode
// - load address is base plus offset
// - load checks tag, aligns data into latch
// - second cache stage latches aligned load data
// - load writes target register in writeback
// - store data passes bypass into shifter
// - store aligns data in execute, before tag access
// - store writes cache only on hit
// - store holds cache two cycles, three with second cache stage, slips follower
// - load after store waits one clock, two with second cache stage
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "cpu_pipe_defs.svh"
module cpu_pipeline_stage_flow (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] icache_vaddr,
	output logic [10:0] icache_index,
	input wire logic [31:0] icache_rdata,
	input wire logic [19:0] icache_tag,
	input wire logic [19:0] inst_page_frame,
	output logic dcache_rd_en,
	output logic [31:0] dcache_rd_addr,
	input wire logic [31:0] dcache_rdata,
	input wire logic [19:0] dcache_tag,
	input wire logic [19:0] data_page_frame,
	output logic dcache_wr_en,
	output logic [31:0] dcache_wr_addr,
	output logic [31:0] dcache_wr_data
);
	// control and exception state
	logic [2:0] ctrl; // run, second cache stage enable, compressed mode
	logic [31:0] exception_return_addr;
	logic [4:0] exception_code_field;
	logic delay_slot_flag;
	logic exception_level_flag;
	logic [31:0] miss_count; // data tag misses seen in the cache stage
	logic run, short_mode, dc2_en;
	// front end latches
	logic [31:0] fetch_pc;
	logic it_valid, rf_valid, rf_slot;
	logic [31:0] it_word, it_pc, rf_word, rf_pc;
	// back end latches: ex_q feeds execute, dc_q is the ALU output latch
	cpu_pipe_pkg::stage_t ex_q, dc_q, c2_q, wb_q, wb_src, next_ex;
	logic [31:0] general_register [0:31];
	// decode and datapath wires
	cpu_pipe_pkg::op_t rf_op;
	logic [4:0] rf_rs, rf_rt;
	logic [31:0] opnd_a, opnd_b, rf_imm, branch_next_pc, ex_out, ex_diff, dc_out;
	logic ic_hit, dc_hit, ex_lt, trap_now, load_slip, store_slip, front_go, redirect;
	logic [31:0] redirect_pc;

	assign run = ctrl[`CTRL_RUN_BIT];
	assign short_mode = ctrl[`CTRL_SHORT_BIT];
	assign dc2_en = ctrl[`CTRL_DC2_BIT];

	// operations that leave a value for the register file
	function automatic logic writes_reg(input cpu_pipe_pkg::op_t o);
		return (o == cpu_pipe_pkg::op_add) || (o == cpu_pipe_pkg::op_jump_link_register_op) || (o == cpu_pipe_pkg::op_lw);
	endfunction

	// bypass select: youngest producer ahead wins, register zero reads zero
	function automatic logic [31:0] bypass(input logic [4:0] idx, input cpu_pipe_pkg::stage_t e,
		input logic [31:0] e_val, input cpu_pipe_pkg::stage_t d, input logic [31:0] d_val,
		input cpu_pipe_pkg::stage_t c, input cpu_pipe_pkg::stage_t w, input logic w_on,
		input logic [31:0] reg_val);
		logic [31:0] v;
		v = reg_val;
		if (idx == 5'h00)
			v = 32'h0000_0000;
		else if (writes_reg(e.op) && e.dst == idx)
			v = e_val;
		else if (writes_reg(d.op) && d.dst == idx)
			v = d_val;
		else if (writes_reg(c.op) && c.dst == idx)
			v = c.res;
		else if (w_on && writes_reg(w.op) && w.dst == idx)
			v = w.res;
		return v;
	endfunction

	// short word to full-width word; there is no short trap form
	function automatic logic [31:0] expand16(input logic [15:0] h);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (h[15:11])
			`C16_ADD: w = {`OPC_SPECIAL, 2'b00, h[7:5], 2'b00, h[4:2], 2'b00, h[10:8], 5'h00, `FN_ADD};
			`C16_JUMP_LINK_REGISTER_OP: w = {`OPC_SPECIAL, 2'b00, h[7:5], 5'h00, 5'h00, 5'h00, `FN_JUMP_LINK_REGISTER_OP};
			`C16_BEQ: w = {`OPC_BEQ, 2'b00, h[10:8], 2'b00, h[7:5], {11{h[4]}}, h[4:0]};
			`C16_LW: w = {`OPC_LW, 2'b00, h[7:5], 2'b00, h[10:8], 9'h000, h[4:0], 2'b00};
			`C16_SW: w = {`OPC_SW, 2'b00, h[7:5], 2'b00, h[10:8], 9'h000, h[4:0], 2'b00};
			default: w = 32'h0000_0000; // unknown short code becomes a bubble
		endcase
		return w;
	endfunction

	// full-width decode; the trap form is refused while in compressed mode
	function automatic cpu_pipe_pkg::op_t decode_op(input logic [31:0] w, input logic short_on);
		cpu_pipe_pkg::op_t o;
		o = cpu_pipe_pkg::op_nop;
		if (w[31:26] == `OPC_SPECIAL && w[5:0] == `FN_ADD)
			o = cpu_pipe_pkg::op_add;
		else if (w[31:26] == `OPC_SPECIAL && w[5:0] == `FN_JUMP_LINK_REGISTER_OP)
			o = cpu_pipe_pkg::op_jump_link_register_op;
		else if (w[31:26] == `OPC_SPECIAL && w[5:0] == `FN_TLT && !short_on)
			o = cpu_pipe_pkg::op_tlt;
		else if (w[31:26] == `OPC_BEQ)
			o = cpu_pipe_pkg::op_beq;
		else if (w[31:26] == `OPC_LW)
			o = cpu_pipe_pkg::op_lw;
		else if (w[31:26] == `OPC_SW)
			o = cpu_pipe_pkg::op_sw;
		return o;
	endfunction

	// fetch side: index with the low address bits, tag against translated frame
	assign icache_vaddr = fetch_pc;
	assign icache_index = fetch_pc[`ICACHE_INDEX_MSB:0];
	assign ic_hit = (icache_tag == inst_page_frame);

	// operand fetch: decode, two register reads with bypass
	assign rf_op = rf_valid ? decode_op(rf_word, short_mode) : cpu_pipe_pkg::op_nop;
	assign rf_rs = rf_word[25:21];
	assign rf_rt = rf_word[20:16];
	assign rf_imm = {{16{rf_word[15]}}, rf_word[15:0]};
	assign opnd_a = bypass(rf_rs, ex_q, ex_out, dc_q, dc_out, c2_q, wb_q, dc2_en,
		general_register[rf_rs]);
	assign opnd_b = bypass(rf_rt, ex_q, ex_out, dc_q, dc_out, c2_q, wb_q, dc2_en,
		general_register[rf_rt]);
	assign branch_next_pc = (opnd_a == opnd_b) ? rf_pc + rf_imm : rf_pc + `PC_STEP;

	// a load in execute has no data yet, so a reader of its target waits a cycle
	assign load_slip = rf_valid && ex_q.op == cpu_pipe_pkg::op_lw && ex_q.dst != 5'h00
		&& (ex_q.dst == rf_rs || ex_q.dst == rf_rt);
	// a store holds the cache from its tag access until its write; a memory op right behind it
	// in execute waits, so it never reads the cache before the store data has landed
	assign store_slip = (ex_q.op == cpu_pipe_pkg::op_lw || ex_q.op == cpu_pipe_pkg::op_sw)
		&& (dc_q.op == cpu_pipe_pkg::op_sw || (dc2_en && c2_q.op == cpu_pipe_pkg::op_sw));
	assign front_go = run && !load_slip && !store_slip;
	assign redirect = rf_op == cpu_pipe_pkg::op_jump_link_register_op
		|| (rf_op == cpu_pipe_pkg::op_beq && opnd_a == opnd_b);
	assign redirect_pc = (rf_op == cpu_pipe_pkg::op_jump_link_register_op) ? opnd_a : branch_next_pc;

	// execute: ALU, subtract for the trap test, address add, store shifter
	assign ex_diff = ex_q.a - ex_q.b;
	assign ex_lt = (ex_q.a[31] != ex_q.b[31]) ? ex_q.a[31] : ex_diff[31];
	assign trap_now = run && ex_q.op == cpu_pipe_pkg::op_tlt && ex_lt;
	always_comb
	begin
		case (ex_q.op)
			cpu_pipe_pkg::op_add: ex_out = ex_q.a + ex_q.b;
			cpu_pipe_pkg::op_jump_link_register_op: ex_out = ex_q.res; // link latch onward
			cpu_pipe_pkg::op_tlt: ex_out = ex_diff;
			cpu_pipe_pkg::op_lw: ex_out = ex_q.a + ex_q.res;
			cpu_pipe_pkg::op_sw: ex_out = ex_q.a + ex_q.res;
			default: ex_out = 32'h0000_0000; // branch and bubble do nothing here
		endcase
	end

	// cache stage: tag check, load data through the aligner (word access, no shift)
	assign dc_hit = (dcache_tag == data_page_frame);
	assign dc_out = (dc_q.op == cpu_pipe_pkg::op_lw) ? dcache_rdata : dc_q.res;
	assign dcache_rd_en = run && (dc_q.op == cpu_pipe_pkg::op_lw || dc_q.op == cpu_pipe_pkg::op_sw);
	assign dcache_rd_addr = dc_q.res;

	// writeback reads the second cache latch only when that stage is switched on
	assign wb_src = dc2_en ? wb_q : c2_q;
	assign dcache_wr_en = run && wb_src.op == cpu_pipe_pkg::op_sw && wb_src.hit;
	assign dcache_wr_addr = wb_src.res;
	assign dcache_wr_data = wb_src.b;

	// fetch program counter: trap vector over redirect over sequential step
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			fetch_pc <= `RESET_PC;
		else if (trap_now)
			fetch_pc <= `TRAP_VECTOR;
		else if (front_go && redirect)
			fetch_pc <= redirect_pc; // valid when the next fetch starts
		else if (front_go && ic_hit)
			fetch_pc <= fetch_pc + `PC_STEP; // a tag miss retries the same address
	end

	// expansion stage latch; the word fetched beside a redirect is dropped
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			it_valid <= 1'b0;
			it_word <= 32'h0000_0000;
			it_pc <= 32'h0000_0000;
		end
		else if (trap_now)
			it_valid <= 1'b0;
		else if (front_go)
		begin
			it_valid <= ic_hit && !redirect;
			it_word <= icache_rdata;
			it_pc <= fetch_pc;
		end
	end

	// operand fetch latch; in compressed mode the slot after a redirect is dropped too
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			rf_valid <= 1'b0;
			rf_word <= 32'h0000_0000;
			rf_pc <= 32'h0000_0000;
			rf_slot <= 1'b0;
		end
		else if (trap_now)
			rf_valid <= 1'b0;
		else if (front_go)
		begin
			rf_valid <= it_valid && !(redirect && short_mode);
			rf_word <= short_mode ? expand16(it_word[15:0]) : it_word;
			rf_pc <= it_pc;
			rf_slot <= (rf_op == cpu_pipe_pkg::op_jump_link_register_op || rf_op == cpu_pipe_pkg::op_beq) && !short_mode;
		end
	end

	// build the execute latch from decoded operands
	always_comb
	begin
		next_ex = '0;
		next_ex.op = rf_op;
		next_ex.pc = rf_pc;
		next_ex.a = opnd_a;
		next_ex.b = opnd_b;
		next_ex.slot = rf_slot;
		next_ex.res = rf_imm; // offset for loads and stores
		next_ex.dst = 5'h00;
		if (rf_op == cpu_pipe_pkg::op_add)
			next_ex.dst = rf_word[15:11];
		else if (rf_op == cpu_pipe_pkg::op_lw)
			next_ex.dst = rf_rt;
		else if (rf_op == cpu_pipe_pkg::op_jump_link_register_op)
		begin
			next_ex.dst = (rf_word[15:11] == 5'h00) ? `LINK_REG : rf_word[15:11];
			next_ex.res = rf_pc + (short_mode ? `LINK_STEP_SHORT : `LINK_STEP_FULL);
		end
	end

	// execute latch: held in a store slip, bubble in a load slip
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			ex_q <= '0;
		else if (trap_now)
			ex_q <= '0;
		else if (run && !store_slip)
			ex_q <= load_slip ? '0 : next_ex;
	end

	// ALU output latch; a store slip sends a bubble down while the back end runs on
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			dc_q <= '0;
		else if (run)
		begin
			if (store_slip)
				dc_q <= '0;
			else
			begin
				dc_q <= ex_q;
				dc_q.res <= ex_out;
				dc_q.b <= ex_q.b << {ex_q.res[1:0] + ex_q.a[1:0], 3'b000}; // main shifter
				dc_q.trap <= trap_now;
			end
		end
	end

	// cache stage output latch and second cache stage latch
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			c2_q <= '0;
			wb_q <= '0;
		end
		else if (run)
		begin
			c2_q <= dc_q; // add and link pass unchanged
			c2_q.res <= dc_out;
			c2_q.hit <= dc_hit; // store data already aligned
			wb_q <= c2_q;
		end
	end

	// register file write port; register zero stays zero
	always_ff @(posedge core_clk)
	begin
		if (run && !rst && writes_reg(wb_src.op) && wb_src.dst != 5'h00)
			general_register[wb_src.dst] <= wb_src.res;
	end

	// exception record; a trap arriving with a software clear keeps the level flag set
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			exception_return_addr <= 32'h0000_0000;
			exception_code_field <= 5'h00;
			delay_slot_flag <= 1'b0;
			exception_level_flag <= 1'b0;
		end
		else if (run && wb_src.trap)
		begin
			exception_return_addr <= wb_src.pc;
			exception_code_field <= `TRAP_CODE;
			delay_slot_flag <= wb_src.slot;
			exception_level_flag <= 1'b1;
		end
		else if (psel && penable && pwrite && paddr == `REG_STATUS && !pwdata[`STATUS_EXL_BIT])
			exception_level_flag <= 1'b0;
	end

	// data tag miss counter, read only
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			miss_count <= 32'h0000_0000;
		else if (dcache_rd_en && !dc_hit)
			miss_count <= miss_count + 32'h0000_0001;
	end

	// known register offsets
	function automatic logic reg_known(input logic [11:0] a);
		return a == `REG_CTRL || a == `REG_EPC || a == `REG_CAUSE || a == `REG_STATUS
			|| a == `REG_FETCH_PC || a == `REG_MISS_COUNT;
	endfunction

	// APB: zero wait states, unmapped offsets answer with an error and no effect
	assign pready = 1'b1;
	assign pslverr = psel && penable && !reg_known(paddr);

	// control register write
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			ctrl <= `CTRL_RESET;
		else if (psel && penable && pwrite && paddr == `REG_CTRL)
			ctrl <= pwdata[2:0];
	end

	// read data is captured in the setup cycle so it leaves a flip-flop in the access cycle
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
		begin
			if (paddr == `REG_CTRL)
				prdata <= {29'h0000_0000, ctrl};
			else if (paddr == `REG_EPC)
				prdata <= exception_return_addr;
			else if (paddr == `REG_CAUSE)
				prdata <= {delay_slot_flag, 24'h00_0000, exception_code_field, 2'b00};
			else if (paddr == `REG_STATUS)
				prdata <= {30'h0000_0000, exception_level_flag, 1'b0};
			else if (paddr == `REG_FETCH_PC)
				prdata <= fetch_pc;
			else if (paddr == `REG_MISS_COUNT)
				prdata <= miss_count;
			else
				prdata <= 32'h0000_0000;
		end
	end

	// checks next to the logic they guard
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	chk_fetch_step: assert property (front_go && !trap_now && !redirect && ic_hit |=> fetch_pc == $past(fetch_pc) + 32'h4)
		else $error("fetch pc did not step by four");
	chk_no_short_trap: assert property (short_mode |-> rf_op != cpu_pipe_pkg::op_tlt)
		else $error("trap op decoded in compressed mode");
	chk_add_passes: assert property (run && dc_q.op == cpu_pipe_pkg::op_add |=> c2_q.res == $past(dc_q.res))
		else $error("add result changed in cache stage");
	chk_link_value: assert property (front_go && rf_op == cpu_pipe_pkg::op_jump_link_register_op && !short_mode && !trap_now
		|=> ex_q.res == $past(rf_pc) + 32'h8 ##1 dc_q.res == $past(rf_pc, 2) + 32'h8)
		else $error("link address wrong");
	chk_link_default: assert property (front_go && !trap_now && rf_op == cpu_pipe_pkg::op_jump_link_register_op
		&& rf_word[15:11] == 5'h00 |=> ex_q.dst == 5'h1f)
		else $error("empty link destination not register 31");
	chk_trap_flush: assert property (trap_now |=> !rf_valid && !it_valid && fetch_pc == 32'h80
		&& ex_q.op == cpu_pipe_pkg::op_nop)
		else $error("trap did not kill younger work");
	chk_trap_record: assert property (run && wb_src.trap |=> exception_level_flag
		&& exception_return_addr == $past(wb_src.pc) && exception_code_field == 5'h0d)
		else $error("trap not recorded");
	chk_store_hit: assert property (dcache_wr_en |-> wb_src.op == cpu_pipe_pkg::op_sw && wb_src.hit)
		else $error("store write without hit");
	chk_store_slip: assert property (run && store_slip |=> dc_q.op == cpu_pipe_pkg::op_nop
		&& ex_q == $past(ex_q))
		else $error("store slip did not hold execute");
	chk_branch_taken: assert property (front_go && !trap_now && rf_op == cpu_pipe_pkg::op_beq
		&& opnd_a == opnd_b |=> fetch_pc == $past(rf_pc) + $past(rf_imm))
		else $error("taken branch target wrong");
endmodule

// file: hw/cpu_pipe_defs.svh
// cpu_pipe_defs.svh: encodings, addresses, register offsets and field positions of the pipeline block
// assumes: included by bare name from the package and from the pipeline module
`ifndef CPU_PIPE_DEFS_SVH
`define CPU_PIPE_DEFS_SVH

// full-width instruction encodings
`define OPC_SPECIAL 6'h00
`define OPC_BEQ 6'h04
`define OPC_LW 6'h23
`define OPC_SW 6'h2b
`define FN_ADD 6'h20
`define FN_JUMP_LINK_REGISTER_OP 6'h09
`define FN_TLT 6'h32
// compressed instruction major codes (bits 15:11 of the short word)
`define C16_ADD 5'h01
`define C16_JUMP_LINK_REGISTER_OP 5'h02
`define C16_BEQ 5'h03
`define C16_LW 5'h04
`define C16_SW 5'h05

// program counter constants
`define RESET_PC 32'h0000_0000
`define TRAP_VECTOR 32'h0000_0080
`define PC_STEP 32'h0000_0004
`define LINK_STEP_FULL 32'h0000_0008
`define LINK_STEP_SHORT 32'h0000_0004
`define LINK_REG 5'h1f
`define ICACHE_INDEX_MSB 10
`define TRAP_CODE 5'h0d

// register offsets (byte addresses)
`define REG_CTRL 12'h000
`define REG_EPC 12'h004
`define REG_CAUSE 12'h008
`define REG_STATUS 12'h00c
`define REG_FETCH_PC 12'h010
`define REG_MISS_COUNT 12'h014
// field positions
`define CTRL_SHORT_BIT 0
`define CTRL_DC2_BIT 1
`define CTRL_RUN_BIT 2
`define CAUSE_BD_BIT 31
`define CAUSE_CODE_LSB 2
`define CAUSE_CODE_MSB 6
`define STATUS_EXL_BIT 1
`define CTRL_RESET 3'h0

`endif

// file: hw/cpu_pipe_pkg.sv
// cpu_pipe_pkg: operation enumeration and stage latch layout for the pipeline block
// assumes: the defines header sits beside it
`include "cpu_pipe_defs.svh"
package cpu_pipe_pkg;
	// operations the pipeline knows; op_nop is the bubble and must stay first
	typedef enum logic [2:0] {op_nop, op_add, op_jump_link_register_op, op_beq, op_tlt, op_lw, op_sw} op_t;
	// one stage output latch
	typedef struct packed {
		op_t op;
		logic [31:0] pc;
		logic [4:0] dst;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] res;
		logic slot;
		logic trap;
		logic hit;
	} stage_t;
endpackage

// file: dv/cache_partner.sv
// cache_partner: behavioural instruction and data caches with translation
// assumes: the pipeline samples every cache answer in the same core_clk cycle
`timescale 1ns/10ps
module cache_partner #(
	parameter logic [31:0] miss_addr = 32'h0000_0130
)(
	input wire logic core_clk,
	input wire logic [31:0] icache_vaddr,
	input wire logic [10:0] icache_index,
	output logic [31:0] icache_rdata,
	output logic [19:0] icache_tag,
	output logic [19:0] inst_page_frame,
	input wire logic dcache_rd_en,
	input wire logic [31:0] dcache_rd_addr,
	output logic [31:0] dcache_rdata,
	output logic [19:0] dcache_tag,
	output logic [19:0] data_page_frame,
	input wire logic dcache_wr_en,
	input wire logic [31:0] dcache_wr_addr,
	input wire logic [31:0] dcache_wr_data
);
	logic [31:0] imem [256]; // program words, loaded by the bench
	logic [31:0] dmem [256]; // data words, loaded by the bench

	// fetch answers from the low index bits, frame taken from the upper address
	always_comb
	begin
		icache_rdata = imem[icache_index[9:2]];
		icache_tag = icache_vaddr[31:12];
		inst_page_frame = icache_vaddr[31:12];
	end

	// data answers; an idle port shows inverted data so stale reads are caught
	always_comb
	begin
		dcache_rdata = dcache_rd_en ? dmem[dcache_rd_addr[9:2]] : ~dmem[dcache_rd_addr[9:2]];
		dcache_tag = dcache_rd_addr[31:12];
		// one address misses so a store there must be dropped
		data_page_frame = (dcache_rd_addr == miss_addr) ? ~dcache_rd_addr[31:12] : dcache_rd_addr[31:12];
	end

	// word writes; plain always so the bench may also preload the array
	always @(posedge core_clk)
	begin
		if (dcache_wr_en === 1'b1)
		begin
			dmem[dcache_wr_addr[9:2]] <= dcache_wr_data;
		end
	end
endmodule

// file: dv/cpu_pipeline_stage_flow_tb.sv
// cpu_pipeline_stage_flow_tb: runs one program through the pipeline, with and without the second cache stage
// assumes: the cache partner model holds program and data arrays reachable by hierarchy
`timescale 1ns/10ps
`include "cpu_pipe_defs.svh"
module cpu_pipeline_stage_flow_tb;
	logic core_clk;
	logic rst;
	logic psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [31:0] icache_vaddr, icache_rdata, dcache_rd_addr, dcache_rdata, dcache_wr_addr, dcache_wr_data;
	logic [10:0] icache_index;
	logic [19:0] icache_tag, inst_page_frame, dcache_tag, data_page_frame;
	logic dcache_rd_en, dcache_wr_en;
	int n_mismatch = 0;
	int check_count = 0;
	logic [31:0] rd; // last read data
	logic er; // last error flag

	cpu_pipeline_stage_flow i_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.icache_vaddr(icache_vaddr), .icache_index(icache_index), .icache_rdata(icache_rdata),
		.icache_tag(icache_tag), .inst_page_frame(inst_page_frame), .dcache_rd_en(dcache_rd_en),
		.dcache_rd_addr(dcache_rd_addr), .dcache_rdata(dcache_rdata), .dcache_tag(dcache_tag),
		.data_page_frame(data_page_frame), .dcache_wr_en(dcache_wr_en), .dcache_wr_addr(dcache_wr_addr),
		.dcache_wr_data(dcache_wr_data));
	cache_partner i_mem (.core_clk(core_clk), .icache_vaddr(icache_vaddr), .icache_index(icache_index),
		.icache_rdata(icache_rdata), .icache_tag(icache_tag), .inst_page_frame(inst_page_frame),
		.dcache_rd_en(dcache_rd_en), .dcache_rd_addr(dcache_rd_addr), .dcache_rdata(dcache_rdata),
		.dcache_tag(dcache_tag), .data_page_frame(data_page_frame), .dcache_wr_en(dcache_wr_en),
		.dcache_wr_addr(dcache_wr_addr), .dcache_wr_data(dcache_wr_data));

	// 25 MHz core clock
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// word compare, counted
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// verdict and end of run
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// one apb transfer: setup, then access held until pready is seen high
	task automatic apb_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// read a register and compare
	task automatic check_rd(input logic [11:0] addr, input logic [31:0] exp);
		apb_xfer(1'b0, addr, 32'h0000_0000);
		check_word(rd, exp);
	endtask

	// full-width encoders
	function automatic logic [31:0] rt_op(input int rs, input int rt, input int rdst, input logic [5:0] fn);
		return {`OPC_SPECIAL, 5'(rs), 5'(rt), 5'(rdst), 5'h00, fn};
	endfunction
	function automatic logic [31:0] im_op(input logic [5:0] op, input int rs, input int rt, input logic [15:0] imm);
		return {op, 5'(rs), 5'(rt), imm};
	endfunction

	// program and data; every dropped or killed slot holds a poison store to 0x124
	task automatic load_image();
		for (int i = 0; i < 256; i++)
		begin
			i_mem.imem[i] = (i < 32) ? im_op(`OPC_SW, 0, 1, 16'h0124) : 32'h0000_0000;
			i_mem.dmem[i] = 32'h0000_0000;
		end
		i_mem.dmem[8'h40] = 32'h0000_0005;
		i_mem.dmem[8'h41] = 32'h0000_0007;
		i_mem.dmem[8'h46] = 32'h0000_0050;
		i_mem.imem[0] = im_op(`OPC_LW, 0, 1, 16'h0100);
		i_mem.imem[1] = im_op(`OPC_LW, 0, 2, 16'h0104);
		i_mem.imem[2] = im_op(`OPC_LW, 0, 7, 16'h0118);
		i_mem.imem[3] = rt_op(1, 2, 3, `FN_ADD); // load-use through bypass
		i_mem.imem[4] = im_op(`OPC_SW, 0, 3, 16'h0108);
		i_mem.imem[5] = im_op(`OPC_LW, 0, 4, 16'h0108); // load right behind a store
		i_mem.imem[6] = im_op(`OPC_SW, 0, 4, 16'h010c);
		i_mem.imem[7] = im_op(`OPC_BEQ, 1, 1, 16'h0010); // taken, target 0x2c
		i_mem.imem[8] = rt_op(1, 1, 5, `FN_ADD); // delay slot runs
		i_mem.imem[11] = im_op(`OPC_SW, 0, 5, 16'h0114);
		i_mem.imem[12] = rt_op(7, 0, 6, `FN_JUMP_LINK_REGISTER_OP); // destination differs from source
		i_mem.imem[13] = rt_op(2, 2, 8, `FN_ADD);
		i_mem.imem[20] = im_op(`OPC_SW, 0, 6, 16'h011c);
		i_mem.imem[21] = im_op(`OPC_SW, 0, 8, 16'h0120);
		i_mem.imem[22] = im_op(`OPC_SW, 0, 1, 16'h0130); // tag miss
		i_mem.imem[23] = rt_op(1, 2, 0, `FN_TLT); // 5 < 7 traps at 0x5c
	endtask

	// watchdog, far beyond two short program runs
	initial
	begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		conclude();
	end

	// main sequence: run once per cache depth
	initial
	begin
		int n;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		rst = 1'b1;
		for (int dc2 = 0; dc2 < 2; dc2++)
		begin
			load_image();
			rst <= 1'b1;
			repeat (2) @(posedge core_clk);
			rst <= 1'b0;
			check_rd(`REG_CTRL, 32'h0000_0000);
			check_rd(`REG_STATUS, 32'h0000_0000);
			apb_xfer(1'b0, 12'h018, 32'h0000_0000);
			check_word({31'h0, er}, 32'h0000_0001);
			apb_xfer(1'b1, `REG_CTRL, 32'h0000_0004 | (32'(dc2) << 1));
			n = 0;
			do
			begin
				apb_xfer(1'b0, `REG_STATUS, 32'h0000_0000);
				n++;
			end
			while (rd[1] !== 1'b1 && n < 200);
			apb_xfer(1'b1, `REG_CTRL, 32'h0000_0000);
			check_rd(`REG_EPC, 32'h0000_005c);
			check_rd(`REG_CAUSE, 32'h0000_0034);
			check_rd(`REG_STATUS, 32'h0000_0002);
			check_word(i_mem.dmem[8'h42], 32'h0000_000c);
			check_word(i_mem.dmem[8'h43], 32'h0000_000c);
			check_word(i_mem.dmem[8'h45], 32'h0000_000a);
			check_word(i_mem.dmem[8'h47], 32'h0000_0038);
			check_word(i_mem.dmem[8'h48], 32'h0000_000e);
			check_word(i_mem.dmem[8'h49], 32'h0000_0000);
			check_word(i_mem.dmem[8'h4c], 32'h0000_0000);
			apb_xfer(1'b1, `REG_EPC, 32'h0000_0000);
			check_rd(`REG_EPC, 32'h0000_005c);
			apb_xfer(1'b1, `REG_STATUS, 32'h0000_0000);
			check_rd(`REG_STATUS, 32'h0000_0000);
		end
		conclude();
	end
endmodule
